// [common/spc_pkg.sv]
// Contract
// - Transmit interrupt needs transmit-empty flag, transmit enable and module enable.
// - Receive/error interrupt follows receive-full when its enable is set, module enable ignored.
// - One error enable gates both overrun and select fault onto receive/error interrupt.
// - With fault detection off the select fault flag never sets.
// - Receive-full clears by status read while set, then data read.
// - Transmit-empty clears only by writing the data register.
// - Receive-full sets when a finished byte enters the receive register.
// - Transmit-empty sets when the transmit byte moves into the shift register.
// - System reset returns every bit and flag to reset state.
// - Module disabled: transmit-empty held set, transfer aborted, shifter and counter cleared, pins released.
//   Code keeps transmit-empty unchanged while disabled in protected break.
// - Control, rate bits and receive flags survive disable; only reset clears them.
// - Master select fault with detection enabled clears module enable.
// - Wait mode: keep running, block CPU access, interrupts wake the processor.
// - Stop mode: freeze and keep registers; reset exit aborts and resets. Code still raises select fault in stop; as master that drops enable and aborts.
// - Break with clear disabled: flags frozen; two-step clear finishes after break.
//   Code still sets transmit-empty on a byte load or a master fault abort.
// - Break with clear enabled: flag clears take effect and persist.
// - Data write during protected break is ignored, starts nothing.
// - Wired-OR mode makes master data output open-drain.
// - Slave data output driven only as slave with select low.
// - Enabled module owns direction of data and clock pins over port register.
// - Master drives serial clock, slave takes it; eight clocks per byte.
// - Master shifts out and samples in at the same time.
// - Unread byte when next completes: set overrun, drop new byte.
// - Select fault: master sees select low, or slave sees select high mid-transfer.
// - Select fault clears by status read while set, then control write, fault gone.
// - Master select fault also sets transmit-empty, clears counter, releases pins.
package spc_pkg;
    // Register offsets on the plain port
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_STATUS  = 2'h1;
    localparam logic [1:0] ADDR_DATA    = 2'h2;
    // Control register bit positions
    localparam int C_RXIE = 7;
    localparam int C_MSTR = 5;
    localparam int C_CPOL = 4;
    localparam int C_CPHA = 3;
    localparam int C_WOM  = 2;
    localparam int C_EN   = 1;
    localparam int C_TXIE = 0;
    // Status register bit positions
    localparam int S_RXF  = 7;
    localparam int S_ERIE = 6;
    localparam int S_OVR  = 5;
    localparam int S_SELECT_FAULT_FLAG = 4;
    localparam int S_TXE  = 3;
    localparam int S_MFEN = 2;
    // Reset values: master set, phase set
    localparam logic [7:0] CONTROL_RESET = 8'h28;
    localparam logic [1:0] RATE_RESET    = 2'h0;
    // Bit count per byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Serial clock half period base in system cycles, scaled by 2^rate
    localparam logic [7:0] HALF_BASE = 8'h04;

    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} spc_phase_t;

    typedef struct packed {
        logic [7:0] control;
        logic [1:0] rate;
        logic       error_irq_enable;
        logic       faultDetEn;
        logic       rxFull;
        logic       overrun;
        logic       selFault;
        logic       txEmpty;
        logic       rxArmed;
        logic       faultArmed;
        logic [7:0] txData;
        logic       txPending;
        logic [7:0] rxData;
        logic [7:0] shifter;
        logic [3:0] bitCnt;
        spc_phase_t phase;
        logic       active;
        logic [7:0] divCnt;
        logic       sckOut;
        logic       sampled;
        logic [1:0] sckSync;
        logic [1:0] misoSync;
        logic [1:0] mosiSync;
        logic [1:0] selSync;
        logic       sckPrev;
        logic       selPrev;
        logic [7:0] rdData;
    } spc_state_t;

    typedef struct packed {
        logic sckOut;
        logic sckOe;
        logic mosiOut;
        logic mosiOe;
        logic misoOut;
        logic misoOe;
    } spc_pins_t;
endpackage : spc_pkg

// [rtl/spc_core.sv]
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module spc_core
    import spc_pkg::*;
(
    // System
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Register port
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStb,
    input  wire logic       rdStb,
    output logic      [7:0] rdData,
    // Power and debug state from the system unit
    input  wire logic       waitMode,
    input  wire logic       stopMode,
    input  wire logic       breakActive,
    input  wire logic       break_clear_enable,
    // Serial pins
    input  wire logic       sckIn,
    input  wire logic       mosiIn,
    input  wire logic       misoIn,
    input  wire logic       selectIn_n,
    output spc_pins_t       pins,
    // Interrupt requests
    output logic            txIrq,
    output logic            rxErrIrq
);
    spc_state_t s;
    spc_state_t next_s;

    // Stepped half period: base shifted by rate bits
    function automatic logic [7:0] halfPeriod(input logic [1:0] r);
        halfPeriod = HALF_BASE << r;
    endfunction : halfPeriod

    always_comb
    begin
        logic en;
        logic mstr;
        logic cpha;
        logic cpol;
        logic rdOk;
        logic wrOk;
        logic flagsLocked;
        logic lead;
        logic trail;
        logic done;
        logic selLow;
        logic sckEdge;
        logic slvActive;
        logic fault;
        en = 1'b0;
        mstr = 1'b0;
        cpha = 1'b0;
        cpol = 1'b0;
        rdOk = 1'b0;
        wrOk = 1'b0;
        flagsLocked = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        done = 1'b0;
        selLow = 1'b0;
        sckEdge = 1'b0;
        slvActive = 1'b0;
        fault = 1'b0;
        next_s = s;
        en = s.control[C_EN];
        mstr = s.control[C_MSTR];
        cpha = s.control[C_CPHA];
        cpol = s.control[C_CPOL];
        // CPU access blocked in wait and stop
        rdOk = rdStb && !waitMode && !stopMode;
        wrOk = wrStb && !waitMode && !stopMode;
        flagsLocked = breakActive && !break_clear_enable;
        selLow = !s.selSync[1];

        // Two-flop synchronisers on every pin input
        next_s.sckSync = {s.sckSync[0], sckIn};
        next_s.misoSync = {s.misoSync[0], misoIn};
        next_s.mosiSync = {s.mosiSync[0], mosiIn};
        next_s.selSync = {s.selSync[0], selectIn_n};
        next_s.sckPrev = s.sckSync[1];
        next_s.selPrev = s.selSync[1];

        // Register reads, data out one cycle later
        next_s.rdData = 8'h00;
        if (rdOk)
        begin
            unique case (addr)
                ADDR_CONTROL: next_s.rdData = s.control;
                ADDR_STATUS:  next_s.rdData = {s.rxFull, s.error_irq_enable, s.overrun, s.selFault,
                                               s.txEmpty, s.faultDetEn, s.rate};
                ADDR_DATA:    next_s.rdData = s.rxData;
                default:      next_s.rdData = 8'h00;
            endcase
        end

        // Status-read arming and data-read clear of two-step clears; frozen in protected break
        if (rdOk && addr == ADDR_STATUS && !flagsLocked)
        begin
            next_s.rxArmed = s.rxFull || s.overrun;
            next_s.faultArmed = s.selFault;
        end
        if (rdOk && addr == ADDR_DATA && s.rxArmed && !flagsLocked)
        begin
            next_s.rxFull = 1'b0;
            next_s.overrun = 1'b0;
            next_s.rxArmed = 1'b0;
        end

        // Select level against mode, found before the writes so a present fault blocks the clear
        slvActive = s.active || (!cpha && !s.selPrev);
        if (s.faultDetEn)
        begin
            if (mstr && selLow)
                fault = 1'b1;
            if (!mstr && !selLow && slvActive)
                fault = 1'b1;
        end

        // Register writes; control and rate kept across disable
        if (wrOk)
        begin
            unique case (addr)
                ADDR_CONTROL:
                begin
                    next_s.control = wrData;
                    if (s.faultArmed && !flagsLocked && !fault)
                    begin
                        next_s.selFault = 1'b0;
                        next_s.faultArmed = 1'b0;
                    end
                end
                ADDR_STATUS:
                begin
                    next_s.error_irq_enable = wrData[S_ERIE];
                    next_s.faultDetEn = wrData[S_MFEN];
                    next_s.rate = wrData[1:0];
                end
                ADDR_DATA:
                begin
                    if (!flagsLocked)
                    begin
                        next_s.txData = wrData;
                        next_s.txPending = 1'b1;
                        next_s.txEmpty = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Only an enabled module raises the flag; set wins over a same-cycle clear
        if (en && fault && !flagsLocked)
            next_s.selFault = 1'b1;
        if (en && fault && mstr)
            next_s.control[C_EN] = 1'b0;

        // Shift engine, frozen in stop mode unless the module is disabled or a master fault aborts it
        if (!en || (fault && mstr))
        begin
            next_s.txEmpty = (flagsLocked && !en) ? s.txEmpty : 1'b1;
            next_s.txPending = 1'b0;
            next_s.active = 1'b0;
            next_s.shifter = 8'h00;
            next_s.bitCnt = 4'h0;
            next_s.phase = ST_IDLE;
            next_s.sckOut = cpol;
            next_s.divCnt = 8'h00;
        end
        else if (!stopMode)
        begin
            // Load from transmit register, marks it empty
            if (!s.active && s.txPending)
            begin
                next_s.shifter = s.txData;
                // A write in this same cycle keeps its byte queued
                if (!(wrOk && addr == ADDR_DATA && !flagsLocked))
                begin
                    next_s.txPending = 1'b0;
                    next_s.txEmpty = 1'b1;
                end
                next_s.bitCnt = 4'h0;
                if (mstr)
                begin
                    next_s.active = 1'b1;
                    next_s.phase = ST_LEAD;
                    next_s.divCnt = 8'h00;
                end
            end
            if (mstr)
            begin
                // Master clock generation
                if (s.active)
                begin
                    if (s.divCnt == halfPeriod(s.rate) - 8'h01)
                    begin
                        next_s.divCnt = 8'h00;
                        next_s.sckOut = ~s.sckOut;
                        if (s.phase == ST_LEAD)
                        begin
                            lead = 1'b1;
                            next_s.phase = ST_TRAIL;
                        end
                        else
                        begin
                            trail = 1'b1;
                            next_s.phase = ST_LEAD;
                        end
                    end
                    else
                        next_s.divCnt = s.divCnt + 8'h01;
                end
                else
                    next_s.sckOut = cpol;
            end
            else if (selLow)
            begin
                // Slave: edges of synchronised clock, ignored when deselected
                sckEdge = s.sckSync[1] != s.sckPrev;
                if (sckEdge)
                begin
                    if (s.sckSync[1] != cpol)
                    begin
                        lead = 1'b1;
                        next_s.active = 1'b1;
                    end
                    else
                        trail = 1'b1;
                end
            end
            else
            begin
                // Deselected slave drops a cut frame and ignores the clock
                next_s.active = 1'b0;
                next_s.bitCnt = 4'h0;
            end

            // Sample on the sampling edge, shift on the other
            if ((lead && !cpha) || (trail && cpha))
                next_s.sampled = mstr ? s.misoSync[1] : s.mosiSync[1];
            // Phase 1 keeps the output still on the sampling edge; its last bit joins at capture
            if ((trail && !cpha) || (lead && cpha && s.bitCnt != 4'h0))
                next_s.shifter = {s.shifter[6:0], s.sampled};
            // Bits counted on trailing edges in both phases
            if (trail)
            begin
                next_s.bitCnt = s.bitCnt + 4'h1;
                done = (s.bitCnt == BITS_PER_BYTE - 4'h1);
            end
            if (done)
            begin
                next_s.active = 1'b0;
                next_s.phase = ST_IDLE;
                next_s.bitCnt = 4'h0;
                if (!flagsLocked)
                begin
                    if (s.rxFull)
                        next_s.overrun = 1'b1;
                    else if (!s.overrun)
                    begin
                        next_s.rxData = cpha ? {s.shifter[6:0], next_s.sampled} : next_s.shifter;
                        next_s.rxFull = 1'b1;
                    end
                end
            end
        end
    end

    // State register; all bits to reset values on system reset
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.control <= CONTROL_RESET;
            s.rate <= RATE_RESET;
            s.txEmpty <= 1'b1;
            // Select idles high; the clock detector stays low, the idle level after reset
            s.selSync <= 2'h3;
            s.selPrev <= 1'b1;
        end
        else
            s <= next_s;
    end

    // Level requests follow flags; they also wake from wait
    assign txIrq = s.txEmpty && s.control[C_TXIE] && s.control[C_EN];
    assign rxErrIrq = (s.rxFull && s.control[C_RXIE])
                    || (s.error_irq_enable && (s.overrun || s.selFault));
    assign rdData = s.rdData;

    // Pin ownership: enabled module overrides port direction
    always_comb
    begin
        logic own;
        own = 1'b0;
        own = s.control[C_EN];
        pins.sckOut = s.sckOut;
        pins.sckOe = own && s.control[C_MSTR];
        pins.mosiOut = s.control[C_WOM] ? 1'b0 : s.shifter[7];
        // Open drain only pulls low in wired-OR mode
        pins.mosiOe = own && s.control[C_MSTR] && (!s.control[C_WOM] || !s.shifter[7]);
        pins.misoOut = s.shifter[7];
        pins.misoOe = own && !s.control[C_MSTR] && !s.selSync[1];
    end
endmodule : spc_core
`default_nettype wire

// [testbench/spc_props.sv]
`timescale 1ns/1ns
`default_nettype none
module spc_props
    import spc_pkg::*;
(
    // System
    input wire logic       clk_sys,
    input wire logic       rst,
    // Register port
    input wire logic [1:0] addr,
    input wire logic [7:0] wrData,
    input wire logic       wrStb,
    input wire logic       rdStb,
    input wire logic [7:0] rdData,
    input wire logic       waitMode,
    input wire logic       stopMode,
    // Pins and requests
    input wire logic       selectIn_n,
    input wire spc_pins_t  pins,
    input wire logic       txIrq,
    input wire logic       rxErrIrq
);
    logic [7:0] ctrlCopy;
    logic       errIeCopy;
    // Copies of software bits; a fault may still drop enable, so they only bound outputs
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrlCopy  <= CONTROL_RESET;
            errIeCopy <= 1'b0;
        end
        else if (wrStb && !waitMode && !stopMode && addr == ADDR_CONTROL)
            ctrlCopy <= wrData;
        else if (wrStb && !waitMode && !stopMode && addr == ADDR_STATUS)
            errIeCopy <= wrData[S_ERIE];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_off;
        !ctrlCopy[C_EN] [*3];
    endsequence
    sequence s_slave;
        !ctrlCopy[C_MSTR] [*3];
    endsequence
    sequence s_desel;
        selectIn_n [*4];
    endsequence
    property p_reset_quiet;
        $fell(rst) |-> !txIrq && !rxErrIrq && !pins.sckOe && !pins.mosiOe && !pins.misoOe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
    property p_tx_gate;
        txIrq |-> ctrlCopy[C_TXIE] && ctrlCopy[C_EN];
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx request ungated");
    property p_rx_gate;
        rxErrIrq |-> ctrlCopy[C_RXIE] || errIeCopy;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx request ungated");
    property p_off;
        s_off |-> !txIrq && !pins.sckOe && !pins.mosiOe && !pins.misoOe;
    endproperty
    a_off: assert property (p_off) else $error("disabled block drives");
    property p_desel;
        s_desel |-> !pins.misoOe;
    endproperty
    a_desel: assert property (p_desel) else $error("deselected slave drives");
    property p_slave_sck;
        s_slave |-> !pins.sckOe && !pins.mosiOe;
    endproperty
    a_slave_sck: assert property (p_slave_sck) else $error("slave drives clock");
    property p_read_idle;
        (!rdStb || waitMode || stopMode) |=> rdData == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data leaked");
    property p_sck_half;
        $changed(pins.sckOut) && pins.sckOe |=> $stable(pins.sckOut) [*3];
    endproperty
    a_sck_half: assert property (p_sck_half) else $error("clock half too short");
endmodule : spc_props
`default_nettype wire

// [testbench/spc_remote.sv]
`timescale 1ns/1ns
`default_nettype none
module spc_remote
(
    // Line levels
    input  wire logic       sckWire,
    input  wire logic       dataIn,
    input  wire logic       remSel_n,
    // Role and payload
    input  wire logic       asMaster,
    input  wire logic       start,
    input  wire logic [7:0] txByte,
    output logic            sckDrive,
    output logic            dataOut,
    output logic [7:0]      rxByte
);
    logic [7:0] sh;
    initial
    begin
        sckDrive = 1'b0;
        dataOut  = 1'b0;
        rxByte   = 8'h00;
        sh       = 8'h00;
    end
    // Slave role, phase 1: launch on rising clock, capture on falling
    always @(negedge remSel_n)
        sh = txByte;
    always @(posedge sckWire)
    begin
        if (!asMaster && !remSel_n)
        begin
            dataOut = sh[7];
            sh      = {sh[6:0], 1'b0};
        end
    end
    always @(negedge sckWire)
        rxByte = {rxByte[6:0], dataIn};
    // Released line flips so a stale level never passes
    always @(posedge remSel_n)
        dataOut = ~dataOut;
    // Master role: eight clocks of 160 ns, still between frames
    always @(posedge start)
    begin
        sh = txByte;
        #13;
        repeat (8)
        begin
            sckDrive = 1'b1;
            dataOut  = sh[7];
            sh       = {sh[6:0], 1'b0};
            #80;
            sckDrive = 1'b0;
            #80;
        end
    end
endmodule : spc_remote
`default_nettype wire

// [testbench/test_spi_irq_reset_pin_control.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module test_spi_irq_reset_pin_control
    import spc_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wrData = 8'h00;
    logic       wrStb = 1'b0;
    logic       rdStb = 1'b0;
    logic       waitMode = 1'b0;
    logic       stopMode = 1'b0;
    logic       breakActive = 1'b0;
    logic       break_clear_enable = 1'b0;
    logic       selectIn_n = 1'b1;
    logic       remSel_n = 1'b1;
    logic       asMaster = 1'b0;
    logic       start = 1'b0;
    logic [7:0] remTx = 8'h00;
    logic [7:0] remRx;
    logic [7:0] rdData;
    logic       txIrq;
    logic       rxErrIrq;
    logic       remSck;
    logic       remData;
    spc_pins_t  pins;
    int         failures = 0;
    int         checks_done = 0;
    int         cycles = 0;
    wire logic  linkClk = pins.sckOe ? pins.sckOut : remSck;
    // Pull-up holds the released line high unless the remote master drives it
    wire logic  mosiW = pins.mosiOe ? pins.mosiOut : (asMaster ? remData : 1'b1);
    wire logic  misoW = pins.misoOe ? pins.misoOut : remData;
    spc_core i_dut (.clk_sys, .rst, .addr, .wrData, .wrStb, .rdStb, .rdData, .waitMode,
        .stopMode, .breakActive, .break_clear_enable, .sckIn(linkClk), .mosiIn(mosiW),
        .misoIn(misoW), .selectIn_n, .pins, .txIrq, .rxErrIrq);
    spc_remote i_remote (.sckWire(linkClk), .dataIn(asMaster ? misoW : mosiW), .remSel_n,
        .asMaster, .start, .txByte(remTx), .sckDrive(remSck), .dataOut(remData), .rxByte(remRx));
    always #10 clk_sys = ~clk_sys;
    // A hang at 20000 cycles counts a failure, then ends through the same verdict task as a normal run
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            conclude();
        end
    end
    task automatic conclude;
        if (failures == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk_sys);
        wrStb  <= 1'b0;
    endtask : wr
    // Data stand only in the cycle after the strobe; sample mid-cycle
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk_sys);
        rdStb <= 1'b0;
        @(negedge clk_sys);
        d = rdData;
        @(posedge clk_sys);
    endtask : rd
    task automatic chk_reg(input logic [1:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask : chk_reg
    task automatic wait_status(input int b);
        logic [7:0] s;
        repeat (200)
        begin
            rd(ADDR_STATUS, s);
            if (s[b] === 1'b1)
                return;
        end
        failures++;
    endtask : wait_status
    task automatic xfer(input logic [7:0] dev, input logic [7:0] rem, input int b);
        remTx <= rem;
        @(posedge clk_sys);
        remSel_n <= 1'b0;
        wr(ADDR_DATA, dev);
        wait_status(b);
        remSel_n <= 1'b1;
    endtask : xfer
    task automatic sc_reset;
        chk_reg(ADDR_CONTROL, 8'h28);
        chk_reg(ADDR_STATUS, 8'h08);
        chk_reg(2'h3, 8'h00);
    endtask : sc_reset
    task automatic sc_master;
        wr(ADDR_CONTROL, 8'h2B);
        @(negedge clk_sys);
        `CHK(txIrq, 1'b1)
        xfer(8'hA5, 8'h3C, S_RXF);
        `CHK(remRx, 8'hA5)
        chk_reg(ADDR_DATA, 8'h3C);
        chk_reg(ADDR_STATUS, 8'h08);
        wr(ADDR_STATUS, 8'h40);
        wr(ADDR_CONTROL, 8'h2F);
        xfer(8'h11, 8'h22, S_RXF);
        `CHK(rxErrIrq, 1'b0)
        `CHK(remRx, 8'h11)
        xfer(8'h33, 8'h44, S_OVR);
        `CHK(rxErrIrq, 1'b1)
        chk_reg(ADDR_STATUS, 8'hE8);
        chk_reg(ADDR_DATA, 8'h22);
        chk_reg(ADDR_STATUS, 8'h48);
    endtask : sc_master
    task automatic sc_fault;
        selectIn_n <= 1'b0;
        chk_reg(ADDR_STATUS, 8'h48);
        wr(ADDR_STATUS, 8'h44);
        repeat (4) @(posedge clk_sys);
        chk_reg(ADDR_STATUS, 8'h5C);
        `CHK(rxErrIrq, 1'b1)
        chk_reg(ADDR_CONTROL, 8'h2D);
        wr(ADDR_CONTROL, 8'hA9);
        chk_reg(ADDR_STATUS, 8'h5C);
        selectIn_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk_reg(ADDR_STATUS, 8'h5C);
        wr(ADDR_CONTROL, 8'hAA);
        chk_reg(ADDR_STATUS, 8'h4C);
        wr(ADDR_STATUS, 8'h00);
        xfer(8'h5A, 8'hC3, S_RXF);
        wr(ADDR_CONTROL, 8'hA8);
        @(negedge clk_sys);
        `CHK(rxErrIrq, 1'b1)
        chk_reg(ADDR_STATUS, 8'h88);
        chk_reg(ADDR_CONTROL, 8'hA8);
    endtask : sc_fault
    task automatic sc_break;
        wr(ADDR_CONTROL, 8'hAA);
        breakActive <= 1'b1;
        chk_reg(ADDR_DATA, 8'hC3);
        wr(ADDR_DATA, 8'h77);
        repeat (100) @(posedge clk_sys);
        chk_reg(ADDR_STATUS, 8'h88);
        breakActive <= 1'b0;
        chk_reg(ADDR_DATA, 8'hC3);
        chk_reg(ADDR_STATUS, 8'h08);
        xfer(8'h0F, 8'hF0, S_RXF);
        breakActive <= 1'b1;
        break_clear_enable <= 1'b1;
        chk_reg(ADDR_DATA, 8'hF0);
        breakActive <= 1'b0;
        break_clear_enable <= 1'b0;
        chk_reg(ADDR_STATUS, 8'h08);
    endtask : sc_break
    task automatic sc_low_power;
        for (int i = 0; i < 2; i++)
        begin
            waitMode <= (i == 0);
            stopMode <= (i == 1);
            wr(ADDR_CONTROL, 8'h00);
            chk_reg(ADDR_CONTROL, 8'h00);
            waitMode <= 1'b0;
            stopMode <= 1'b0;
            chk_reg(ADDR_CONTROL, 8'hAA);
        end
    endtask : sc_low_power
    task automatic sc_slave;
        wr(ADDR_CONTROL, 8'h0A);
        wr(ADDR_DATA, 8'h5A);
        selectIn_n <= 1'b0;
        asMaster <= 1'b1;
        remTx <= 8'h96;
        repeat (4) @(posedge clk_sys);
        start <= 1'b1;
        `CHK(pins.misoOe, 1'b1)
        wait_status(S_RXF);
        start <= 1'b0;
        `CHK(remRx, 8'h5A)
        chk_reg(ADDR_DATA, 8'h96);
        selectIn_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(pins.misoOe, 1'b0)
    endtask : sc_slave
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        sc_reset();
        sc_master();
        sc_fault();
        sc_break();
        sc_low_power();
        sc_slave();
        conclude();
    end
endmodule : test_spi_irq_reset_pin_control
bind spc_core spc_props i_props (.clk_sys, .rst, .addr, .wrData, .wrStb, .rdStb, .rdData,
    .waitMode, .stopMode, .selectIn_n, .pins, .txIrq, .rxErrIrq);
`default_nettype wire
